// File: design/scrb_serial_bank.sv
// Two-wire serial slave holding the first nine control registers.
// Assumes an external master, pull-ups on both lines, mclk at 10 MHz.
`timescale 1ns/1ps
`default_nettype none
module scrb_serial_bank (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  output logic                       charge_status_out,
  output logic                       charge_status_oe,
  output scrb_pkg::scrb_enables_t    enables,
  output logic                       content_adaptive_enable,
  output logic                       keypad_serial_switch,
  output logic [7:0]                 backlight_led_enable,
  output logic [7:0]                 regulator_one_two_voltage,
  output logic [7:0]                 regulator_three_boost_voltage,
  output logic [7:0]                 main_led_level,
  output logic [7:0]                 sub_led_level_5,
  output logic [7:0]                 sub_led_level_6,
  output logic [7:0]                 sub_led_level_7
);

  scrb_pkg::scrb_bus_events_t ev;

  scrb_line_sync u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .events (ev)
  );

  function automatic logic [7:0] reset_value(input int idx);
    case (idx)
      0:       reset_value = scrb_pkg::RST_POWER_ENABLE;
      1:       reset_value = scrb_pkg::RST_BACKLIGHT_EN;
      2:       reset_value = scrb_pkg::RST_DIMMING_CTRL;
      3:       reset_value = scrb_pkg::RST_REG12_VOLTAGE;
      4:       reset_value = scrb_pkg::RST_REG3_BOOST_VOLT;
      default: reset_value = scrb_pkg::RST_LED_LEVEL;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] ptr);
    reg_hit = (ptr <= scrb_pkg::REG_LAST);
  endfunction

  scrb_pkg::scrb_state_t state;
  scrb_pkg::scrb_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] reg_ptr;
  logic [7:0] next_reg_ptr;
  logic       ptr_loaded;
  logic       next_ptr_loaded;
  logic       drive_low;
  logic       next_drive_low;
  logic       master_nak;
  logic       next_master_nak;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] regs      [scrb_pkg::REG_COUNT];
  logic [7:0] next_regs [scrb_pkg::REG_COUNT];
  logic [7:0] rd_word;

  always_comb begin
    rd_word = 8'h00;
    if (reg_hit(reg_ptr)) begin
      rd_word = regs[reg_ptr[3:0]];
    end
  end

  // Byte engine: shifts in on clock rises, shifts out and changes drive on clock falls
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_reg_ptr    = reg_ptr;
    next_ptr_loaded = ptr_loaded;
    next_drive_low  = drive_low;
    next_master_nak = master_nak;
    wr_en           = 1'b0;
    wr_data         = shift;
    if (ev.stop) begin
      next_state     = scrb_pkg::SCRB_IDLE;
      next_drive_low = 1'b0;
    end else if (ev.start) begin
      // Repeated start also lands here
      next_state      = scrb_pkg::SCRB_ADDR;
      next_bit_cnt    = 4'h0;
      next_drive_low  = 1'b0;
      next_ptr_loaded = 1'b0;
    end else begin
      case (state)
        scrb_pkg::SCRB_ADDR, scrb_pkg::SCRB_WDATA: begin
          if (ev.rise) begin
            next_shift   = {shift[6:0], ev.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (ev.fall && bit_cnt == scrb_pkg::BIT_COUNT_LAST + 4'h1) begin
            next_bit_cnt = 4'h0;
            if (state == scrb_pkg::SCRB_ADDR) begin
              if (shift[7:1] == scrb_pkg::SLAVE_ADDR) begin
                next_drive_low = 1'b1;
                next_state     = scrb_pkg::SCRB_ADDR_AK;
              end else begin
                next_state = scrb_pkg::SCRB_IGNORE;
              end
            end else begin
              next_drive_low = 1'b1;
              next_state     = scrb_pkg::SCRB_WDAT_AK;
              if (!ptr_loaded) begin
                next_reg_ptr    = shift;
                next_ptr_loaded = 1'b1;
              end else begin
                wr_en        = reg_hit(reg_ptr);
                next_reg_ptr = reg_ptr + 8'h01;
              end
            end
          end
        end
        scrb_pkg::SCRB_ADDR_AK: begin
          // Held low across the whole high phase of the ninth pulse
          if (ev.fall) begin
            if (shift[0]) begin
              next_state     = scrb_pkg::SCRB_RDATA;
              next_shift     = rd_word;
              next_drive_low = ~rd_word[7];
              next_reg_ptr   = reg_ptr + 8'h01;
            end else begin
              next_drive_low = 1'b0;
              next_state     = scrb_pkg::SCRB_WDATA;
            end
          end
        end
        scrb_pkg::SCRB_WDAT_AK: begin
          if (ev.fall) begin
            next_drive_low = 1'b0;
            next_state     = scrb_pkg::SCRB_WDATA;
          end
        end
        scrb_pkg::SCRB_RDATA: begin
          if (ev.fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == scrb_pkg::BIT_COUNT_LAST) begin
              next_bit_cnt   = 4'h0;
              next_drive_low = 1'b0;
              next_state     = scrb_pkg::SCRB_RDAT_AK;
            end else begin
              next_shift     = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
            end
          end
        end
        scrb_pkg::SCRB_RDAT_AK: begin
          if (ev.rise) begin
            next_master_nak = ev.sda;
          end else if (ev.fall) begin
            if (master_nak) begin
              next_state = scrb_pkg::SCRB_IGNORE;
            end else begin
              next_state     = scrb_pkg::SCRB_RDATA;
              next_shift     = rd_word;
              next_drive_low = ~rd_word[7];
              next_reg_ptr   = reg_ptr + 8'h01;
            end
          end
        end
        scrb_pkg::SCRB_IDLE, scrb_pkg::SCRB_IGNORE: begin
          next_drive_low = 1'b0;
        end
        default: begin
          next_state     = scrb_pkg::SCRB_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= scrb_pkg::SCRB_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      reg_ptr    <= 8'h00;
      ptr_loaded <= 1'b0;
      drive_low  <= 1'b0;
      master_nak <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      reg_ptr    <= next_reg_ptr;
      ptr_loaded <= next_ptr_loaded;
      drive_low  <= next_drive_low;
      master_nak <= next_master_nak;
    end
  end

  // Soft reset bit restores defaults one cycle after written, then clears itself
  logic       soft_reset;
  logic [7:0] power_word;
  logic [7:0] dimming_word;
  assign power_word   = regs[scrb_pkg::OFS_POWER_ENABLE[3:0]];
  assign dimming_word = regs[scrb_pkg::OFS_DIMMING_CTRL[3:0]];
  assign soft_reset   = power_word[scrb_pkg::BIT_SOFT_RESET];

  genvar gi;
  generate
    for (gi = 0; gi < scrb_pkg::REG_COUNT; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (soft_reset) begin
          next_regs[gi] = reset_value(gi);
        end else if (wr_en && reg_ptr[3:0] == 4'(gi)) begin
          next_regs[gi] = wr_data;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs[gi] <= reset_value(gi);
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  assign charge_status_out = 1'b0;
  assign charge_status_oe  = dimming_word[scrb_pkg::BIT_CHARGE_STATUS];

  always_comb begin
    enables.step_up    = power_word[scrb_pkg::BIT_STEP_UP_EN];
    enables.regulators = {power_word[scrb_pkg::BIT_REG1_EN], power_word[scrb_pkg::BIT_REG2_EN],
                          power_word[scrb_pkg::BIT_REG3_EN]};
    enables.main_led   = power_word[scrb_pkg::BIT_MAIN_LED_EN];
    enables.keypad_alc = power_word[scrb_pkg::BIT_KEYPAD_ALC_EN];
    enables.ambient    = power_word[scrb_pkg::BIT_AMBIENT_EN];
  end

  assign content_adaptive_enable = dimming_word[scrb_pkg::BIT_CONTENT_ADAPT];
  assign keypad_serial_switch    = dimming_word[scrb_pkg::BIT_KEYPAD_SWITCH];
  assign backlight_led_enable    = regs[scrb_pkg::OFS_BACKLIGHT_EN[3:0]];
  assign regulator_one_two_voltage     = regs[scrb_pkg::OFS_REG12_VOLTAGE[3:0]];
  assign regulator_three_boost_voltage = regs[scrb_pkg::OFS_REG3_BOOST_VOLT[3:0]];
  // Raw linear codes; analog side gives (n+1) steps of 0.1 mA
  assign main_led_level  = regs[scrb_pkg::OFS_MAIN_LED[3:0]];
  assign sub_led_level_5 = regs[scrb_pkg::OFS_SUB_LED5[3:0]];
  assign sub_led_level_6 = regs[scrb_pkg::OFS_SUB_LED6[3:0]];
  assign sub_led_level_7 = regs[scrb_pkg::OFS_SUB_LED7[3:0]];

endmodule
`default_nettype wire

// File: design/scrb_pkg.sv
// Constants, register map and carrier types for the serial control register bank.
// Assumes a 10 MHz system clock that oversamples the two-wire bus many times per bit.
// Behaviour
// - Answer slave address 1110110, write EC, read ED.
// - One bit per clock; data stable while clock high.
// - Both lines idle high between transfers.
// - Data falling with clock high starts frame.
// - Data rising with clock high ends transaction.
// - No limit on bytes per transaction.
// - Each byte followed by acknowledge slot.
// - Acknowledge address and every received data byte.
// - Acknowledger holds data low through high phase.
// - Released line after master's missing acknowledge.
// - Charge status pulls low while its bit set.
// - LED codes linear, (n+1) times 0.1 mA.
// - Power enable bit 7 resets, others enable blocks.
// - Registers take listed defaults at every reset.
package scrb_pkg;

  localparam logic [6:0] SLAVE_ADDR = 7'h76;
  localparam int         REG_COUNT  = 9;
  localparam logic [7:0] REG_LAST   = 8'h08;

  localparam logic [7:0] OFS_POWER_ENABLE    = 8'h00;
  localparam logic [7:0] OFS_BACKLIGHT_EN    = 8'h01;
  localparam logic [7:0] OFS_DIMMING_CTRL    = 8'h02;
  localparam logic [7:0] OFS_REG12_VOLTAGE   = 8'h03;
  localparam logic [7:0] OFS_REG3_BOOST_VOLT = 8'h04;
  localparam logic [7:0] OFS_MAIN_LED        = 8'h05;
  localparam logic [7:0] OFS_SUB_LED5        = 8'h06;
  localparam logic [7:0] OFS_SUB_LED6        = 8'h07;
  localparam logic [7:0] OFS_SUB_LED7        = 8'h08;

  localparam logic [7:0] RST_POWER_ENABLE    = 8'h00;
  localparam logic [7:0] RST_BACKLIGHT_EN    = 8'h00;
  localparam logic [7:0] RST_DIMMING_CTRL    = 8'h26;
  localparam logic [7:0] RST_REG12_VOLTAGE   = 8'h6c;
  localparam logic [7:0] RST_REG3_BOOST_VOLT = 8'hba;
  localparam logic [7:0] RST_LED_LEVEL       = 8'h01;

  localparam int BIT_SOFT_RESET     = 7;
  localparam int BIT_STEP_UP_EN     = 6;
  localparam int BIT_REG1_EN        = 5;
  localparam int BIT_REG2_EN        = 4;
  localparam int BIT_REG3_EN        = 3;
  localparam int BIT_MAIN_LED_EN    = 2;
  localparam int BIT_KEYPAD_ALC_EN  = 1;
  localparam int BIT_AMBIENT_EN     = 0;
  localparam int BIT_CHARGE_STATUS  = 6;
  localparam int BIT_CONTENT_ADAPT  = 7;
  localparam int BIT_KEYPAD_SWITCH  = 5;

  localparam logic [3:0] BIT_COUNT_LAST = 4'h7;

  // LED current step, in microamps
  localparam int LED_STEP_UA = 100;

  typedef enum logic [2:0] {
    SCRB_IDLE    = 3'b000,
    SCRB_ADDR    = 3'b001,
    SCRB_ADDR_AK = 3'b011,
    SCRB_WDATA   = 3'b010,
    SCRB_WDAT_AK = 3'b110,
    SCRB_RDATA   = 3'b111,
    SCRB_RDAT_AK = 3'b101,
    SCRB_IGNORE  = 3'b100
  } scrb_state_t;

  typedef struct packed {
    logic       step_up;
    logic [2:0] regulators;
    logic       main_led;
    logic       keypad_alc;
    logic       ambient;
  } scrb_enables_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } scrb_bus_events_t;

endpackage

// File: design/scrb_line_sync.sv
// Synchronises the bus clock and data pins and reports edges, start and stop.
// Assumes both pins are idle high and far slower than mclk.
`timescale 1ns/1ps
`default_nettype none
module scrb_line_sync (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output scrb_pkg::scrb_bus_events_t      events
);

  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_old;
  logic       sda_old;
  logic [1:0] next_scl_meta;
  logic [1:0] next_sda_meta;

  always_comb begin
    next_scl_meta = {scl_meta[0], scl_in};
    next_sda_meta = {sda_meta[0], sda_in};
  end

  // Idle value high so release from reset shows no false edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_old  <= 1'b1;
      sda_old  <= 1'b1;
    end else begin
      scl_meta <= next_scl_meta;
      sda_meta <= next_sda_meta;
      scl_old  <= scl_meta[1];
      sda_old  <= sda_meta[1];
    end
  end

  always_comb begin
    events.rise  = scl_meta[1] & ~scl_old;
    events.fall  = ~scl_meta[1] & scl_old;
    events.start = scl_meta[1] & scl_old & sda_old & ~sda_meta[1];
    events.stop  = scl_meta[1] & scl_old & ~sda_old & sda_meta[1];
    events.sda   = sda_meta[1];
  end

endmodule
`default_nettype wire

// File: verification/scrb_serial_bank_asserts.sv
// Port-level assertions for the serial control register bank.
// Assumes it is bound to scrb_serial_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scrb_serial_bank_asserts (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       charge_status_out,
  input wire logic       charge_status_oe,
  input wire logic [7:0] main_led_level,
  input wire logic [7:0] sub_led_level_7,
  input wire logic [7:0] regulator_three_boost_voltage
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Cycles the bus clock has sat high, saturating
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  always_comb begin
    next_idle_cnt = (idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1;
    if (!scl_in) next_idle_cnt = 4'h0;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) idle_cnt <= 4'h0;
    else idle_cnt <= next_idle_cnt;
  end
  property p_oe_changes_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_changes_low: assert property (p_oe_changes_low) else $error("data drive moved in clock high");
  property p_ack_hold;
    $rose(scl_in) |=> $stable(sda_oe) [*2];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data drive not held over clock high");
  property p_idle_release;
    idle_cnt > 4'h7 |-> !sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data line held on idle bus");
  property p_open_drain;
    !sda_out && !charge_status_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain output drove high");
  property p_charge_low;
    $changed(charge_status_oe) |-> !scl_in;
  endproperty
  a_charge_low: assert property (p_charge_low) else $error("charge pin moved in clock high");
  property p_regs_idle_stable;
    idle_cnt > 4'h7 |-> $stable(main_led_level) && $stable(regulator_three_boost_voltage);
  endproperty
  a_regs_idle_stable: assert property (p_regs_idle_stable) else $error("register moved on idle bus");
  property p_reset_defaults;
    $rose(rst_n) |-> main_led_level == 8'h01 && sub_led_level_7 == 8'h01 &&
      regulator_three_boost_voltage == 8'hba && !charge_status_oe;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("register not at default");
  property p_led_update_low;
    $changed(main_led_level) || $changed(sub_led_level_7) |-> !scl_in;
  endproperty
  a_led_update_low: assert property (p_led_update_low) else $error("level code moved in clock high");
endmodule
`default_nettype wire

// File: verification/scrb_bus_master.sv
// Two-wire bus master model: start, stop and byte transfer tasks.
// Assumes the bench resolves the data line with a pull-up into sda_bus.
`timescale 1ns/1ps
`default_nettype none
module scrb_bus_master (
  input  wire logic mclk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Five low and three high per 800 ns bit; data moves only while low
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda_bus;
    scl <= 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_drv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(8);
  endtask
  // Ninth clock is the acknowledge slot; ack_in high releases the line
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// File: verification/scrb_serial_bank_tb_top.sv
// Self-checking bench for the serial control register bank.
// Assumes the bus master model and the checker compile beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: value differs", $time); end end
module scrb_serial_bank_tb_top;
  logic                   mclk;
  logic                   rst_n;
  logic                   scl;
  logic                   sda_drv;
  logic                   sda_out;
  logic                   sda_oe;
  logic                   charge_status_out;
  logic                   charge_status_oe;
  scrb_pkg::scrb_enables_t enables;
  logic                   content_adaptive_enable;
  logic                   keypad_serial_switch;
  logic [7:0]             backlight_led_enable;
  logic [7:0]             regulator_one_two_voltage;
  logic [7:0]             regulator_three_boost_voltage;
  logic [7:0]             main_led_level;
  logic [7:0]             sub_led_level_5;
  logic [7:0]             sub_led_level_6;
  logic [7:0]             sub_led_level_7;
  int                     miscompares;
  int                     num_checks;
  integer                 seed;
  logic [7:0]             exp [9];
  logic [7:0]             wq [$];
  // Pull-up: the line is low whenever either side pulls
  wire logic              sda_bus = sda_drv & !(sda_oe & !sda_out);
  scrb_serial_bank i_scrb_serial_bank (
    .mclk, .rst_n, .scl_in(scl), .sda_in(sda_bus), .sda_out, .sda_oe, .charge_status_out,
    .charge_status_oe, .enables, .content_adaptive_enable, .keypad_serial_switch,
    .backlight_led_enable, .regulator_one_two_voltage, .regulator_three_boost_voltage,
    .main_led_level, .sub_led_level_5, .sub_led_level_6, .sub_led_level_7);
  scrb_bus_master i_scrb_bus_master (.mclk, .sda_bus, .scl, .sda_drv);
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic void load_defaults();
    exp = '{8'h00, 8'h00, 8'h26, 8'h6c, 8'hba, 8'h01, 8'h01, 8'h01, 8'h01};
  endfunction
  function automatic void model_write(input int p, input logic [7:0] d);
    if (p == 0 && d[7]) load_defaults();
    else if (p <= 8) exp[p] = d;
  endfunction
  task automatic check_outs();
    `CHK(enables, exp[0][6:0])
    `CHK(({content_adaptive_enable, charge_status_oe, keypad_serial_switch}), exp[2][7:5])
    `CHK(({backlight_led_enable, regulator_one_two_voltage}), ({exp[1], exp[3]}))
    `CHK(regulator_three_boost_voltage, exp[4])
    `CHK(({main_led_level, sub_led_level_5}), ({exp[5], exp[6]}))
    `CHK(({sub_led_level_6, sub_led_level_7}), ({exp[7], exp[8]}))
  endtask
  task automatic send(input logic [7:0] d, input logic e_ack);
    logic [7:0] q;
    logic a;
    i_scrb_bus_master.xfer(d, 1'b1, q, a);
    `CHK(a, e_ack)
  endtask
  task automatic reg_write(input int p, input logic [7:0] dq [$]);
    i_scrb_bus_master.start();
    send(8'hec, 1'b0);
    send(8'(p), 1'b0);
    foreach (dq[i]) begin
      send(dq[i], 1'b0);
      model_write(p + i, dq[i]);
    end
    i_scrb_bus_master.stop();
  endtask
  task automatic reg_read(input int p, input int n, input bit sr = 1'b1);
    logic [7:0] q;
    logic a;
    i_scrb_bus_master.start();
    send(8'hec, 1'b0);
    send(8'(p), 1'b0);
    // Without a repeated start the pointer must survive the stop
    if (!sr) i_scrb_bus_master.stop();
    i_scrb_bus_master.start();
    send(8'hed, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_scrb_bus_master.xfer(8'hff, i == n - 1, q, a);
      `CHK(q, (p + i <= 8) ? exp[p + i] : 8'h00)
    end
    i_scrb_bus_master.stop();
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    results();
  end
  initial begin
    seed = 32'hdda8_817b;
    rst_n = 1'b0;
    load_defaults();
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check_outs();
    reg_read(0, 9);
    repeat (4) begin
      wq = {};
      repeat (9) wq.push_back(8'($random(seed)));
      wq[0][7] = 1'b0;
      reg_write(0, wq);
      check_outs();
      reg_read(0, 9);
    end
    wq = {8'h40};
    reg_write(2, wq);
    check_outs();
    wq = {8'h00};
    reg_write(2, wq);
    check_outs();
    // Runs past the last register: the tail is acknowledged and dropped
    wq = {8'hff, 8'h00, 8'h5a, 8'ha5, 8'h3c};
    reg_write(6, wq);
    check_outs();
    reg_read(9, 1);
    i_scrb_bus_master.start();
    send(8'hee, 1'b1);
    send(8'h00, 1'b1);
    i_scrb_bus_master.stop();
    wq = {8'h80};
    reg_write(0, wq);
    check_outs();
    reg_read(0, 9);
    wq = {8'h77, 8'h3c};
    reg_write(5, wq);
    reg_read(5, 2, 1'b0);
    // Reset in mid-run with the bus idle: every register back to default
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    load_defaults();
    repeat (4) @(posedge mclk);
    check_outs();
    reg_read(5, 2);
    results();
  end
endmodule
bind scrb_serial_bank scrb_serial_bank_asserts i_scrb_serial_bank_asserts (
  .mclk, .rst_n, .scl_in, .sda_out, .sda_oe, .charge_status_out, .charge_status_oe,
  .main_led_level, .sub_led_level_7, .regulator_three_boost_voltage);
`default_nettype wire
